// file: design/scx_regs.svh
// constants of the crosspoint configuration slave
`ifndef SCX_REGS_SVH
`define SCX_REGS_SVH
// -----------------------------------------------------------------
// register pointers
// -----------------------------------------------------------------
`define SCX_PTR_ROUTE      8'h00
`define SCX_PTR_TXEMPH     8'h01
`define SCX_PTR_RXEQ       8'h02
`define SCX_PTR_CTRL       8'h03
`define SCX_PTR_LOSS       8'h04
// -----------------------------------------------------------------
// reset values and fields
// -----------------------------------------------------------------
`define SCX_RST_ROUTE      8'h00
`define SCX_RST_TXEMPH     8'h00
`define SCX_RST_RXEQ       8'h00
`define SCX_RST_CTRL       8'h0F
`define SCX_CTRL_PWDN_LSB  0
`define SCX_CTRL_EQ_OVR    4
`define SCX_CTRL_TXE_OVR   5
`define SCX_CTRL_MON_EN    6
`define SCX_CTRL_SOFT_UP   7
`define SCX_FIELD_W        2
`define SCX_LEVEL_OFF      2'h0
`define SCX_LEVEL_LOW      2'h1
`define SCX_LEVEL_MED      2'h2
// -----------------------------------------------------------------
// link framing
// -----------------------------------------------------------------
`define SCX_ADDR_HI        3'h5
`define SCX_BIT_LAST       4'h7
`define SCX_BIT_ACK        4'h8
// -----------------------------------------------------------------
// positions in the synchronised input vector
// -----------------------------------------------------------------
`define SCX_SY_W           19
`define SCX_SY_WR          0
`define SCX_SY_PTR         1
`define SCX_SY_PWDN        2
`define SCX_SY_STRAP       3
`define SCX_SY_EMPH        7
`define SCX_SY_EQ          11
`define SCX_SY_LOSS        15
`endif

// file: design/scx_pkg.sv
// types of the crosspoint configuration slave
package scx_pkg;
   typedef enum logic [2:0] {
      SCX_IDLE  = 3'b000,
      SCX_ADDR  = 3'b001,
      SCX_PTR   = 3'b010,
      SCX_WDATA = 3'b011,
      SCX_RDATA = 3'b100
   } scx_state_t;
endpackage

// file: design/scx_crosspoint_cfg.sv
// serial management slave and configuration registers of the crosspoint
//
// Notes on behaviour
// (R01) host opens with START, 7-bit address and write direction bit 0
// (R02) device pulls data low in ninth bit after its own address
// (R03) host sends 8-bit pointer, device acknowledges it low
// (R04) one data byte follows pointer, acknowledged and stored in register
// (R05) host ends a write with STOP, bus then idles
// (R06) read: repeated START, address again with direction bit 1
// (R07) read address acknowledged, then selected register shifted out
// (R08) host answers data byte with not-acknowledge then STOP
// (R09) pointers 0..3 read/write registers, pointer 4 read-only status
// (R10) routing holds four 2-bit fields ascending per output, reset 00
// (R11) routing field code n selects input n, inputs may fan out
// (R12) unused inputs powered down from current routing, outputs by control bits 3..0; control bit 6 keeps all inputs on
// (R13) emphasis register four 2-bit fields per output, reset 00
// (R14) emphasis codes: off, low, medium, high
// (R15) equalizer register four 2-bit fields per input, reset 00
// (R16) equalizer codes: off, low, medium, high
// (R17) address is 101 above four strap bits
// (R18) control bits 5 and 4 choose register over level pins
// (R19) pointers above 4 acknowledged, writes dropped, reads zero
`include "scx_regs.svh"
module scx_crosspoint_cfg
   import scx_pkg::*;
(
   // system side
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // serial link, open drain data
   input  wire logic       sclClk,
   input  wire logic       sdaIn,
   output wire logic       sdaOut,
   output wire logic       sdaOe,
   // pins from the board
   input  wire logic [3:0] slaveIdStraps,
   input  wire logic       pwdnPin,
   input  wire logic [3:0] emphasisPins,
   input  wire logic [3:0] equalizerPins,
   input  wire logic [3:0] signalLossMonitor,
   // configuration to the analog paths
   output logic      [7:0] routeSelect,
   output logic      [7:0] transmitEmphasis,
   output logic      [7:0] receiveEqualizer,
   output logic      [3:0] outputEnable,
   output logic      [3:0] inputEnable
);
   // -----------------------------------------------------------------
   // link domain
   // -----------------------------------------------------------------
   scx_state_t       linkSt_q;
   scx_state_t       nextSt_q;
   logic       [3:0] bitCnt_q;
   logic       [6:0] shift_q;
   logic             ack_q;
   logic             startTgl_q;
   logic             startSeen_q;
   logic       [7:0] ptr_q;
   logic             ptrTgl_q;
   logic       [7:0] wrData_q;
   logic             wrTgl_q;
   logic             sdaOe_q;
   logic             startNew;
   logic             byteDone;
   logic       [7:0] rxByte;
   logic             addrHit;
   // system domain
   logic [`SCX_SY_W-1:0] sy1_q;
   logic [`SCX_SY_W-1:0] sy2_q;
   logic [`SCX_SY_W-1:0] sy3_q;
   logic [`SCX_SY_W-1:0] filt_q;
   logic [`SCX_SY_W-1:0] prev_q;
   logic       [7:0] route_q;
   logic       [7:0] txEmph_q;
   logic       [7:0] rxEq_q;
   logic       [7:0] ctrl_q;
   logic       [7:0] rdSnap_q;
   logic             wrEv;
   logic             ptrEv;
   logic       [3:0] inUsed;
   logic             powerUp;

   // level that a single pin selects when the register is not in charge
   function automatic logic [7:0] pinLevels(input logic [3:0] pins,
                                            input logic [1:0] onCode);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 4; i++) begin
         r[i*`SCX_FIELD_W +: `SCX_FIELD_W] = pins[i] ? onCode : `SCX_LEVEL_OFF;
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // start detection
   // -----------------------------------------------------------------
   // data falling while the clock is high; the link domain takes the
   // toggle a whole low phase later, so it is settled by then
   always_ff @(negedge sdaIn or negedge rst_n) begin
      if (!rst_n) begin
         startTgl_q <= 1'b0;
      end else if (sclClk) begin
         startTgl_q <= ~startTgl_q; // R01 R06
      end
   end

   assign startNew = startTgl_q != startSeen_q;
   assign rxByte   = {shift_q, sdaIn};
   assign byteDone = !startNew && linkSt_q != SCX_IDLE
                     && bitCnt_q == `SCX_BIT_LAST;
   assign addrHit  = rxByte[7:1] == {`SCX_ADDR_HI, filt_q[`SCX_SY_STRAP +: 4]}; // R17

   // -----------------------------------------------------------------
   // byte framing on the rising clock
   // -----------------------------------------------------------------
   // a STOP needs no edge of its own: the writes are already taken with
   // the eighth data bit and the next START restarts the framing
   always_ff @(posedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         linkSt_q    <= SCX_IDLE;
         nextSt_q    <= SCX_IDLE;
         bitCnt_q    <= 4'h0;
         shift_q     <= 7'h00;
         ack_q       <= 1'b0;
         startSeen_q <= 1'b0;
      end else if (startNew) begin
         startSeen_q <= startTgl_q;
         linkSt_q    <= SCX_ADDR;
         bitCnt_q    <= 4'h1;
         shift_q     <= {6'h00, sdaIn};
         ack_q       <= 1'b0;
      end else if (linkSt_q != SCX_IDLE) begin
         if (bitCnt_q == `SCX_BIT_ACK) begin
            bitCnt_q <= 4'h0;
            linkSt_q <= nextSt_q; // R05 R08
            ack_q    <= 1'b0;
         end else begin
            shift_q  <= rxByte[6:0];
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == `SCX_BIT_LAST) begin
               unique case (linkSt_q)
                  SCX_ADDR: begin
                     ack_q    <= addrHit; // R02 R07
                     nextSt_q <= !addrHit ? SCX_IDLE
                                 : (rxByte[0] ? SCX_RDATA : SCX_PTR); // R06
                  end
                  SCX_PTR: begin
                     ack_q    <= 1'b1; // R03 R19
                     nextSt_q <= SCX_WDATA;
                  end
                  SCX_WDATA: begin
                     ack_q    <= 1'b1; // R04
                     nextSt_q <= SCX_IDLE;
                  end
                  SCX_RDATA: begin
                     ack_q    <= 1'b0; // R08
                     nextSt_q <= SCX_IDLE;
                  end
                  default: begin
                     ack_q    <= 1'b0;
                     nextSt_q <= SCX_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // pointer and data stay still until the next byte of their kind, so
   // the system side can read them after the toggle arrives
   always_ff @(posedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q    <= 8'h00;
         ptrTgl_q <= 1'b0;
         wrData_q <= 8'h00;
         wrTgl_q  <= 1'b0;
      end else if (byteDone && linkSt_q == SCX_PTR) begin
         ptr_q    <= rxByte; // R03
         ptrTgl_q <= ~ptrTgl_q;
      end else if (byteDone && linkSt_q == SCX_WDATA) begin
         wrData_q <= rxByte; // R04
         wrTgl_q  <= ~wrTgl_q;
      end
   end

   // -----------------------------------------------------------------
   // data drive on the falling clock
   // -----------------------------------------------------------------
   always_ff @(negedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         sdaOe_q <= 1'b0;
      end else if (bitCnt_q == `SCX_BIT_ACK) begin
         sdaOe_q <= ack_q; // R02 R03 R04
      end else if (linkSt_q == SCX_RDATA) begin
         sdaOe_q <= !rdSnap_q[3'(`SCX_BIT_LAST - bitCnt_q)]; // R07
      end else begin
         sdaOe_q <= 1'b0;
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe  = sdaOe_q;

   // -----------------------------------------------------------------
   // system side: three-stage capture of the pins and the link toggles
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sy1_q  <= '0;
         sy2_q  <= '0;
         sy3_q  <= '0;
         filt_q <= '0;
         prev_q <= '0;
      end else begin
         sy1_q  <= {signalLossMonitor, equalizerPins, emphasisPins,
                    slaveIdStraps, pwdnPin, ptrTgl_q, wrTgl_q};
         sy2_q  <= sy1_q;
         sy3_q  <= sy2_q;
         filt_q <= (sy2_q & sy3_q) | (filt_q & (sy2_q ^ sy3_q));
         prev_q <= filt_q;
      end
   end

   assign wrEv  = filt_q[`SCX_SY_WR] ^ prev_q[`SCX_SY_WR];
   assign ptrEv = filt_q[`SCX_SY_PTR] ^ prev_q[`SCX_SY_PTR];

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         route_q  <= `SCX_RST_ROUTE; // R10
         txEmph_q <= `SCX_RST_TXEMPH; // R13
         rxEq_q   <= `SCX_RST_RXEQ; // R15
         ctrl_q   <= `SCX_RST_CTRL;
      end else if (wrEv) begin
         unique case (ptr_q)
            `SCX_PTR_ROUTE:  route_q  <= wrData_q; // R09 R10
            `SCX_PTR_TXEMPH: txEmph_q <= wrData_q; // R13 R14
            `SCX_PTR_RXEQ:   rxEq_q   <= wrData_q; // R15 R16
            `SCX_PTR_CTRL:   ctrl_q   <= wrData_q; // R09
            default: ; // R19
         endcase
      end
   end

   // snapshot for the read path, taken when the pointer arrives
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdSnap_q <= 8'h00;
      end else if (ptrEv) begin
         unique case (ptr_q)
            `SCX_PTR_ROUTE:  rdSnap_q <= route_q; // R09
            `SCX_PTR_TXEMPH: rdSnap_q <= txEmph_q;
            `SCX_PTR_RXEQ:   rdSnap_q <= rxEq_q;
            `SCX_PTR_CTRL:   rdSnap_q <= ctrl_q;
            `SCX_PTR_LOSS:   rdSnap_q <= {4'h0, filt_q[`SCX_SY_LOSS +: 4]};
            default:         rdSnap_q <= 8'h00; // R19
         endcase
      end
   end

   // -----------------------------------------------------------------
   // analog configuration
   // -----------------------------------------------------------------
   always_comb begin
      inUsed = 4'h0;
      for (int o = 0; o < 4; o++) begin
         inUsed[route_q[o*`SCX_FIELD_W +: `SCX_FIELD_W]] = 1'b1; // R11 R12
      end
   end

   assign powerUp = filt_q[`SCX_SY_PWDN] | ctrl_q[`SCX_CTRL_SOFT_UP];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         routeSelect      <= 8'h00;
         transmitEmphasis <= 8'h00;
         receiveEqualizer <= 8'h00;
         outputEnable     <= 4'h0;
         inputEnable      <= 4'h0;
      end else begin
         routeSelect      <= route_q; // R11
         transmitEmphasis <= ctrl_q[`SCX_CTRL_TXE_OVR] ? txEmph_q
            : pinLevels(filt_q[`SCX_SY_EMPH +: 4], `SCX_LEVEL_MED); // R18
         receiveEqualizer <= ctrl_q[`SCX_CTRL_EQ_OVR] ? rxEq_q
            : pinLevels(filt_q[`SCX_SY_EQ +: 4], `SCX_LEVEL_LOW); // R18
         outputEnable     <= {4{powerUp}}
                             & ctrl_q[`SCX_CTRL_PWDN_LSB +: 4]; // R12
         inputEnable      <= ({4{powerUp}} & inUsed)
                             | {4{ctrl_q[`SCX_CTRL_MON_EN]}}; // R12
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence addrMatched;
      linkSt_q == SCX_ADDR && bitCnt_q == `SCX_BIT_LAST && !startNew
      && addrHit;
   endsequence
   sequence ackHeld;
      bitCnt_q == `SCX_BIT_ACK && ack_q;
   endsequence

   AST_ADDR_ACK: assert property (@(posedge sclClk) disable iff (!rst_n) // R02
      addrMatched |=> ackHeld ##0 sdaOe_q)
      else $error("own address not acknowledged");
   AST_ADDR_MISS: assert property (@(posedge sclClk) disable iff (!rst_n) // R17
      (linkSt_q == SCX_ADDR && bitCnt_q == `SCX_BIT_LAST && !startNew
       && !addrHit) |=> !sdaOe_q ##1 linkSt_q == SCX_IDLE)
      else $error("foreign address acknowledged");
   AST_PTR_ACK: assert property (@(posedge sclClk) disable iff (!rst_n) // R03
      (byteDone && linkSt_q == SCX_PTR) |=> sdaOe_q && ptr_q == $past(rxByte))
      else $error("pointer not taken or not acknowledged");
   AST_READ_ENTRY: assert property (@(posedge sclClk) disable iff (!rst_n) // R07
      (addrMatched ##0 rxByte[0]) |=> ackHeld ##1 linkSt_q == SCX_RDATA)
      else $error("read address did not start data phase");
   AST_READ_NOACK: assert property (@(posedge sclClk) disable iff (!rst_n) // R08
      (linkSt_q == SCX_RDATA && bitCnt_q == `SCX_BIT_ACK) |-> !sdaOe_q)
      else $error("slave drove the host acknowledge slot");
   AST_WRITE_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R04
      (wrEv && ptr_q == `SCX_PTR_ROUTE) |=> route_q == $past(wrData_q))
      else $error("routing write not stored");
   AST_WRITE_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
      (wrEv && ptr_q > `SCX_PTR_LOSS) |=> $stable(route_q) && $stable(ctrl_q))
      else $error("out of range write changed a register");
   AST_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
      (ptrEv && ptr_q > `SCX_PTR_LOSS) |=> rdSnap_q == 8'h00)
      else $error("out of range read not zero");
   AST_EMPH_PINS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
      !ctrl_q[`SCX_CTRL_TXE_OVR] |=> transmitEmphasis
         == pinLevels($past(filt_q[`SCX_SY_EMPH +: 4]), `SCX_LEVEL_MED))
      else $error("emphasis pins not followed");
   AST_IN_SHUT: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
      (!inUsed[0] && !ctrl_q[`SCX_CTRL_MON_EN]) |=> !inputEnable[0])
      else $error("unused input left powered");
   AST_RESET_VAL: assert property (@(posedge clk_sys) // R10
      !rst_n |=> route_q == 8'h00 && txEmph_q == 8'h00 && rxEq_q == 8'h00)
      else $error("register reset value wrong");
endmodule

// file: verif/scx_host_model.sv
// behavioural serial management host driving the crosspoint slave
module scx_host_model (
   // link to the slave, data is open drain with a pull-up
   output logic      sclClk,
   output logic      hostOe,
   input  wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 100ps;

   // clock stands high between frames, host releases data
   initial begin
      sclClk = 1'b1;
      hostOe = 1'b0;
   end

   // -----------------------------------------------------------------
   // bit level, 32 ns per bit, data moves only while the clock is low except at START and STOP
   // -----------------------------------------------------------------
   task automatic bitOut(input logic b, output logic s);
      #8 hostOe = ~b;
      #8 sclClk = 1'b1;
      #8 s = sdaLine;
      #8 sclClk = 1'b0;
   endtask

   // msb first, ninth bit released so the slave can answer
   task automatic byteOut(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitOut(b[i], s);
      bitOut(1'b1, ack);
   endtask

   task automatic startCond;
      #8 hostOe = 1'b0;
      #8 sclClk = 1'b1;
      #8 hostOe = 1'b1;
      #8 sclClk = 1'b0;
   endtask

   task automatic stopCond;
      #8 hostOe = 1'b1;
      #8 sclClk = 1'b1;
      #8 hostOe = 1'b0;
      #8;
   endtask

   // -----------------------------------------------------------------
   // transactions
   // -----------------------------------------------------------------
   task automatic header(input logic [6:0] adr, input logic [7:0] ptr,
                         output logic [1:0] ack);
      startCond();
      byteOut({adr, 1'b0}, ack[1]);
      byteOut(ptr, ack[0]);
   endtask

   // the trailing gap lets the slave hand the byte to the system side
   task automatic wrReg(input logic [6:0] adr, input logic [7:0] ptr,
                        input logic [7:0] d, output logic [2:0] ack);
      header(adr, ptr, ack[2:1]);
      byteOut(d, ack[0]);
      stopCond();
      #200;
   endtask

   task automatic rdReg(input logic [6:0] adr, input logic [7:0] ptr,
                        output logic [7:0] d, output logic [2:0] ack);
      logic s;
      header(adr, ptr, ack[2:1]);
      #200;
      startCond();
      byteOut({adr, 1'b1}, ack[0]);
      for (int i = 7; i >= 0; i--) bitOut(1'b1, d[i]);
      bitOut(1'b1, s);
      stopCond();
      #200;
   endtask
endmodule

// file: verif/tb_scx_crosspoint_cfg.sv
// self-checking bench of the crosspoint configuration slave
module tb_scx_crosspoint_cfg;
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic       clk_sys;
   logic       rst_n;
   logic       sclClk;
   logic       hostOe;
   logic       sdaLine;
   logic       sdaOut;
   logic       sdaOe;
   logic [3:0] slaveIdStraps;
   logic       pwdnPin;
   logic [3:0] emphasisPins;
   logic [3:0] equalizerPins;
   logic [3:0] signalLossMonitor;
   logic [7:0] routeSelect;
   logic [7:0] transmitEmphasis;
   logic [7:0] receiveEqualizer;
   logic [3:0] outputEnable;
   logic [3:0] inputEnable;
   logic [2:0] ack;
   logic [7:0] rd;
   int         bad_count;
   int         checked;
   int         cycles;
   // 101 above the strap value 4'hA
   localparam logic [6:0] DEV = 7'h5A;
   logic [7:0]  rstVal [5] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h09};
   logic [7:0]  newVal [4] = '{8'hE4, 8'hE4, 8'h1B, 8'h3F};
   // power pin, route, control, expected output and input enables
   logic [24:0] pwr [6] = '{{1'b1, 8'h55, 8'h3F, 4'hF, 4'h2},
                            {1'b1, 8'h55, 8'h7F, 4'hF, 4'hF},
                            {1'b0, 8'h55, 8'h3F, 4'h0, 4'h0},
                            {1'b0, 8'h55, 8'hBF, 4'hF, 4'h2},
                            {1'b1, 8'h12, 8'h35, 4'h5, 4'h7},
                            {1'b0, 8'h12, 8'h7F, 4'h0, 4'hF}};

   // wired-and of both open drain parties with a pull-up
   assign sdaLine = hostOe ? 1'b0 : (sdaOe ? sdaOut : 1'b1);

   scx_crosspoint_cfg scx_crosspoint_cfg_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sclClk(sclClk),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .slaveIdStraps(slaveIdStraps), .pwdnPin(pwdnPin),
      .emphasisPins(emphasisPins), .equalizerPins(equalizerPins),
      .signalLossMonitor(signalLossMonitor), .routeSelect(routeSelect),
      .transmitEmphasis(transmitEmphasis),
      .receiveEqualizer(receiveEqualizer),
      .outputEnable(outputEnable), .inputEnable(inputEnable));

   scx_host_model scx_host_model_i (
      .sclClk(sclClk), .hostOe(hostOe), .sdaLine(sdaLine));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic summarize;
      $display("mismatches %0d of %0d checks", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // compare away from the clock edge so registered outputs have landed
   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] seen);
      @(negedge clk_sys);
      checked++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      scx_host_model_i.wrReg(DEV, ptr, d, ack);
      check("write acks", 8'h00, {5'h00, ack});
   endtask

   task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
      scx_host_model_i.rdReg(DEV, ptr, rd, ack);
      check("read acks", 8'h00, {5'h00, ack});
      check("read data", exp, rd);
   endtask

   // hang guard, the full run needs well under a tenth of this
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         summarize();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      logic       pw;
      logic [7:0] rt;
      logic [7:0] ct;
      logic [3:0] eo;
      logic [3:0] ei;
      rst_n = 1'b0;
      pwdnPin = 1'b1;
      slaveIdStraps = 4'hA;
      emphasisPins = 4'h5;
      equalizerPins = 4'h3;
      signalLossMonitor = 4'h9;
      bad_count = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (20) @(negedge clk_sys);
      // pins govern the levels until the override bits are set
      check("route out", 8'h00, routeSelect);
      check("emphasis out", 8'h22, transmitEmphasis);
      check("equalizer out", 8'h05, receiveEqualizer);
      check("output enable", 8'h0F, {4'h0, outputEnable});
      check("input enable", 8'h01, {4'h0, inputEnable});
      for (int p = 0; p < 5; p++) rdchk(p[7:0], rstVal[p]);
      for (int p = 0; p < 4; p++) wr(p[7:0], newVal[p]);
      for (int p = 0; p < 4; p++) rdchk(p[7:0], newVal[p]);
      check("route out", 8'hE4, routeSelect);
      check("emphasis out", 8'hE4, transmitEmphasis);
      check("equalizer out", 8'h1B, receiveEqualizer);
      check("input enable", 8'h0F, {4'h0, inputEnable});
      for (int i = 0; i < 6; i++) begin
         {pw, rt, ct, eo, ei} = pwr[i];
         @(negedge clk_sys);
         pwdnPin = pw;
         wr(8'h00, rt);
         wr(8'h03, ct);
         check("output enable", {4'h0, eo}, {4'h0, outputEnable});
         check("input enable", {4'h0, ei}, {4'h0, inputEnable});
      end
      // another slave's address must be ignored entirely
      scx_host_model_i.wrReg(7'h55, 8'h00, 8'hFF, ack);
      check("foreign acks", 8'h07, {5'h00, ack});
      rdchk(8'h00, 8'h12);
      wr(8'h07, 8'hAA);
      rdchk(8'h07, 8'h00);
      @(negedge clk_sys);
      signalLossMonitor = 4'h6;
      wr(8'h04, 8'hFF);
      rdchk(8'h04, 8'h06);
      summarize();
   end
endmodule
